// *** hw/irq_mask_pkg.sv ***
// constants for the framer interrupt masking block
package irq_mask_pkg;

    // register offsets on the parallel bus
    localparam logic [4:0] CTRL_OFS = 5'h19;
    localparam logic [4:0] VECTOR_OFS = 5'h1a;
    localparam logic [4:0] MASK0_OFS = 5'h1b;
    localparam logic [4:0] MASK1_OFS = 5'h1c;
    localparam logic [4:0] MASK2_OFS = 5'h1d;

    // values after reset
    localparam logic [7:0] MASK0_RST = 8'h00;
    localparam logic [7:0] MASK1_RST = 8'h00;
    localparam logic [7:0] MASK2_RST = 8'h00;
    localparam logic [7:0] VECTOR_RST = 8'h00;

    // control word fields
    localparam int SUSPEND_BIT = 6;
    localparam int ACK_BIT = 5;

    // mask word zero fields (zero enables)
    localparam int M0_SYNC = 7;
    localparam int M0_RAI = 6;
    localparam int M0_AIS = 5;
    localparam int M0_AIS16 = 4;
    localparam int M0_LOS = 3;
    localparam int M0_FAS = 2;
    localparam int M0_BPVWRAP = 1;
    localparam int M0_SLIP = 0;

    // mask word one fields (one enables)
    localparam int M1_FAREND = 7;
    localparam int M1_CRC = 6;
    localparam int M1_DBLFAS = 5;
    localparam int M1_BPV = 4;
    localparam int M1_LONG = 3;
    localparam int M1_WIN = 2;
    localparam int M1_BERT = 1;
    localparam int M1_SIG = 0;

    // mask word two fields (one enables)
    localparam int M2_FAROVF = 7;
    localparam int M2_CRCOVF = 6;
    localparam int M2_CALIGN = 5;
    localparam int M2_FASOVF = 4;
    localparam int M2_JIT = 3;
    localparam int M2_BERTOVF = 2;
    localparam int M2_AUX = 1;
    localparam int M2_MFOVF = 0;

    // vector category bit positions
    localparam int VEC_SYNC = 7;
    localparam int VEC_ALARM = 6;
    localparam int VEC_ERROR = 5;
    localparam int VEC_OVF = 4;
    localparam int VEC_ALIGN = 3;
    localparam int VEC_SLIP = 2;
    localparam int VEC_SIG = 0;

    // alarm-with-crc timing
    localparam int CLK_KHZ = 100000;
    localparam int ALARM_LONG_MS = 10;
    localparam int ALARM_WIN_MS = 450;
    localparam int ALARM_LONG_CYC = ALARM_LONG_MS * CLK_KHZ;
    localparam int ALARM_WIN_CYC = ALARM_WIN_MS * CLK_KHZ;

endpackage

// *** hw/level_change_detect.sv ***
// rise and any-change detection on a group of status levels
`timescale 1ns/1ps
module level_change_detect
    import irq_mask_pkg::*;
#(
    parameter int WIDTH = 2
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] change
);

    logic [WIDTH-1:0] prev_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            prev_ff <= '0;
        else
            prev_ff <= level;
    end

    assign rise = level & ~prev_ff;
    assign change = level ^ prev_ff;

endmodule

// *** hw/e1_framer_interrupt_masking.sv ***
// interrupt source gating, category vector and request pin of the e1 framer
`timescale 1ns/1ps
module e1_framer_interrupt_masking
    import irq_mask_pkg::*;
#(
    parameter int LONG_CYCLES = ALARM_LONG_CYC,
    parameter int WIN_CYCLES = ALARM_WIN_CYC
)
(
    input wire logic clk,
    input wire logic rstn,
    // parallel register port
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // conditions and events from the framer datapath
    input wire logic frame_sync_loss,
    input wire logic remote_alarm,
    input wire logic all_ones_alarm,
    input wire logic ch16_all_ones_alarm,
    input wire logic signal_loss,
    input wire logic align_word_error,
    input wire logic line_violation_wrap,
    input wire logic frame_slip,
    input wire logic far_end_crc_error,
    input wire logic local_crc_error,
    input wire logic double_align_error,
    input wire logic line_violation,
    input wire logic alarm_crc_level,
    input wire logic tester_bit_error,
    input wire logic signalling_change,
    input wire logic far_end_count_ovf,
    input wire logic crc_count_ovf,
    input wire logic align_count_ovf,
    input wire logic tester_count_ovf,
    input wire logic multiframe_count_ovf,
    input wire logic crc_align_status,
    input wire logic jitter_fifo_margin,
    input wire logic aux_pattern_status,
    // interrupt request pin, active low
    output logic irq_n,
    output logic irq_oe
);

    logic [7:0] mask0_ff;
    logic [7:0] mask1_ff;
    logic [7:0] mask2_ff;
    logic [7:0] vector_ff;
    logic [7:0] nxt_vector;
    logic suspend_ff;
    logic ack_ff;
    logic ack_toggle;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [31:0] alarm_cnt_ff;
    logic alarm_prev_ff;
    logic [1:0] st_rise;
    logic [1:0] st_change;
    logic long_hit;
    logic win_hit;
    logic [7:0] raw_vec;
    logic [7:0] set_vec;
    logic irq_n_ff;

    // mask word zero fields are active low enables
    wire frame_sync_loss_irq_en = ~mask0_ff[M0_SYNC];
    wire remote_alarm_irq_en = ~mask0_ff[M0_RAI];
    wire all_ones_alarm_irq_en = ~mask0_ff[M0_AIS];
    wire ch16_all_ones_alarm_irq_en = ~mask0_ff[M0_AIS16];
    wire signal_loss_irq_en = ~mask0_ff[M0_LOS];
    wire align_word_error_irq_en = ~mask0_ff[M0_FAS];
    wire line_violation_wrap_irq_en = ~mask0_ff[M0_BPVWRAP];
    wire frame_slip_irq_en = ~mask0_ff[M0_SLIP];

    // mask words one and two are active high enables
    wire far_end_crc_irq_en = mask1_ff[M1_FAREND];
    wire local_crc_irq_en = mask1_ff[M1_CRC];
    wire double_align_error_irq_en = mask1_ff[M1_DBLFAS];
    wire line_violation_irq_en = mask1_ff[M1_BPV];
    wire alarm_crc_long_irq_en = mask1_ff[M1_LONG];
    wire alarm_crc_window_irq_en = mask1_ff[M1_WIN];
    wire tester_bit_error_irq_en = mask1_ff[M1_BERT];
    wire signalling_change_irq_en = mask1_ff[M1_SIG];
    wire far_end_count_ovf_irq_en = mask2_ff[M2_FAROVF];
    wire crc_count_ovf_irq_en = mask2_ff[M2_CRCOVF];
    wire crc_align_change_irq_en = mask2_ff[M2_CALIGN];
    wire align_count_ovf_irq_en = mask2_ff[M2_FASOVF];
    wire jitter_fifo_margin_irq_en = mask2_ff[M2_JIT];
    wire tester_count_ovf_irq_en = mask2_ff[M2_BERTOVF];
    wire aux_pattern_irq_en = mask2_ff[M2_AUX];
    wire multiframe_count_ovf_irq_en = mask2_ff[M2_MFOVF];

    // one decode for every writable register, so all write ports agree on the offset
    function automatic logic wr_hit(input logic stb, input logic [4:0] a, input logic [4:0] ofs);
        return stb && (a == ofs);
    endfunction

    wire wr_ctrl = wr_hit(wr, addr, CTRL_OFS);
    wire wr_mask0 = wr_hit(wr, addr, MASK0_OFS);
    wire wr_mask1 = wr_hit(wr, addr, MASK1_OFS);
    wire wr_mask2 = wr_hit(wr, addr, MASK2_OFS);

    // status levels compared with their value one cycle earlier
    level_change_detect #(
        .WIDTH(2)
    ) u_status_edges (
        .clk(clk),
        .rstn(rstn),
        .level({aux_pattern_status, crc_align_status}),
        .rise(st_rise),
        .change(st_change)
    );

    // duration of the alarm-with-crc condition; saturates past the window
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            alarm_cnt_ff <= 32'h0;
        else if (!alarm_crc_level)
            alarm_cnt_ff <= 32'h0;
        else if (alarm_cnt_ff < 32'(WIN_CYCLES))
            alarm_cnt_ff <= alarm_cnt_ff + 32'h1;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            alarm_prev_ff <= 1'b0;
        else
            alarm_prev_ff <= alarm_crc_level;
    end

    // strictly longer than the limit: fire one cycle past the count
    assign long_hit = alarm_crc_level && (alarm_cnt_ff == 32'(LONG_CYCLES));
    // judged when the condition ends, since only then is the duration known
    assign win_hit = alarm_prev_ff && !alarm_crc_level
        && (alarm_cnt_ff > 32'(LONG_CYCLES))
        && (alarm_cnt_ff < 32'(WIN_CYCLES));

    // each source gated by its own enable before the categories merge
    wire sync_loss_evt = frame_sync_loss_irq_en && frame_sync_loss;
    wire remote_alarm_evt = remote_alarm_irq_en && remote_alarm;
    wire all_ones_evt = all_ones_alarm_irq_en && all_ones_alarm;
    wire ch16_alarm_evt = ch16_all_ones_alarm_irq_en && ch16_all_ones_alarm;
    wire signal_loss_evt = signal_loss_irq_en && signal_loss;
    wire align_err_evt = align_word_error_irq_en && align_word_error;
    wire wrap_evt = line_violation_wrap_irq_en && line_violation_wrap;
    wire slip_evt = frame_slip_irq_en && frame_slip;
    wire far_end_crc_evt = far_end_crc_irq_en && far_end_crc_error;
    wire local_crc_evt = local_crc_irq_en && local_crc_error;
    wire double_align_evt = double_align_error_irq_en && double_align_error;
    wire violation_evt = line_violation_irq_en && line_violation;
    wire alarm_long_evt = alarm_crc_long_irq_en && long_hit;
    wire alarm_window_evt = alarm_crc_window_irq_en && win_hit;
    wire tester_err_evt = tester_bit_error_irq_en && tester_bit_error;
    wire signalling_evt = signalling_change_irq_en && signalling_change;
    wire far_end_ovf_evt = far_end_count_ovf_irq_en && far_end_count_ovf;
    wire crc_ovf_evt = crc_count_ovf_irq_en && crc_count_ovf;
    wire align_ovf_evt = align_count_ovf_irq_en && align_count_ovf;
    wire tester_ovf_evt = tester_count_ovf_irq_en && tester_count_ovf;
    wire mframe_ovf_evt = multiframe_count_ovf_irq_en && multiframe_count_ovf;
    wire crc_align_evt = crc_align_change_irq_en && st_change[0];
    wire jitter_evt = jitter_fifo_margin_irq_en && jitter_fifo_margin;
    wire aux_rise_evt = aux_pattern_irq_en && st_rise[1];

    always_comb
    begin
        raw_vec = 8'h00;
        raw_vec[VEC_SYNC] = sync_loss_evt;
        raw_vec[VEC_ALARM] = remote_alarm_evt || all_ones_evt || ch16_alarm_evt || signal_loss_evt
            || aux_rise_evt;
        raw_vec[VEC_ERROR] = align_err_evt || far_end_crc_evt || local_crc_evt || double_align_evt
            || violation_evt || alarm_long_evt || alarm_window_evt || tester_err_evt;
        raw_vec[VEC_OVF] = wrap_evt || far_end_ovf_evt || crc_ovf_evt || align_ovf_evt
            || tester_ovf_evt || mframe_ovf_evt;
        raw_vec[VEC_ALIGN] = crc_align_evt;
        raw_vec[VEC_SLIP] = slip_evt || jitter_evt;
        raw_vec[VEC_SIG] = signalling_evt;
    end

    // suspended sources are dropped, not deferred
    assign set_vec = suspend_ff ? 8'h00 : raw_vec;

    // either direction of the bit counts, so compare with the stored level
    assign ack_toggle = wr_ctrl && (wdata[ACK_BIT] != ack_ff);

    // a new event in the acknowledge cycle survives the clear
    assign nxt_vector = (ack_toggle ? 8'h00 : vector_ff) | set_vec;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            vector_ff <= VECTOR_RST;
        else
            vector_ff <= nxt_vector;
    end

    // registered so the pin cannot glitch while vector bits change
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            irq_n_ff <= 1'b1;
        else
            irq_n_ff <= ~(|nxt_vector);
    end

    // masks take effect from the cycle after the write
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mask0_ff <= MASK0_RST;
            mask1_ff <= MASK1_RST;
            mask2_ff <= MASK2_RST;
        end
        else
        begin
            if (wr_mask0)
                mask0_ff <= wdata;
            if (wr_mask1)
                mask1_ff <= wdata;
            if (wr_mask2)
                mask2_ff <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            suspend_ff <= 1'b0;
            ack_ff <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            suspend_ff <= wdata[SUSPEND_BIT];
            ack_ff <= wdata[ACK_BIT];
        end
    end

    // read mux; unmapped offsets read zero
    always_comb
    begin
        nxt_rdata = 8'h00;
        case (addr)
            CTRL_OFS:
            begin
                nxt_rdata[SUSPEND_BIT] = suspend_ff;
                nxt_rdata[ACK_BIT] = ack_ff;
            end
            VECTOR_OFS: nxt_rdata = vector_ff;
            MASK0_OFS: nxt_rdata = mask0_ff;
            MASK1_OFS: nxt_rdata = mask1_ff;
            MASK2_OFS: nxt_rdata = mask2_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    // data held between reads so the host sees a stable byte
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata_ff <= 8'h00;
        else if (rd)
            rdata_ff <= nxt_rdata;
    end

    assign rdata = rdata_ff;

    // pin low while anything is pending; released under suspend
    assign irq_n = irq_n_ff;
    assign irq_oe = ~suspend_ff;

endmodule

// *** tb/host_bus.sv ***
// host processor model on the parallel register port
`timescale 1ns/1ps
module host_bus
(
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [4:0] addr = 5'h00,
    output logic [7:0] wdata = 8'h00,
    output logic wr = 1'b0,
    output logic rd = 1'b0
);
    // strobe cycle then idle cycle, so back-to-back calls never collide
    task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // rdata holds until the next strobe, so sample one edge later
    task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
endmodule

// *** tb/irq_mask_props.sv ***
// port assertions for the interrupt masking block
`timescale 1ns/1ps
module irq_mask_props
    import irq_mask_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic frame_sync_loss,
    input wire logic frame_slip,
    input wire logic irq_n,
    input wire logic irq_oe
);
    logic [7:0] m0_ff;
    logic [1:0] ctl_ff;
    wire logic wr_ctl = wr && addr == CTRL_OFS;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            m0_ff <= MASK0_RST;
            ctl_ff <= 2'h0;
        end
        else
        begin
            if (wr && addr == MASK0_OFS)
                m0_ff <= wdata;
            if (wr_ctl)
                ctl_ff <= wdata[6:5];
        end
    end
    sequence s_read(logic [4:0] a);
        rd && addr == a;
    endsequence
    a_reset_idle: assert property ($rose(rstn) |-> irq_n && irq_oe)
        else $error("request active after reset");
    a_sync_raises: assert property (frame_sync_loss && !m0_ff[M0_SYNC] && !ctl_ff[1]
        && !wr |=> !irq_n)
        else $error("sync loss gave no request");
    a_slip_raises: assert property (frame_slip && !m0_ff[M0_SLIP] && !ctl_ff[1]
        && !wr |=> !irq_n)
        else $error("slip gave no request");
    a_request_sticky: assert property (!irq_n && !wr_ctl |=> !irq_n)
        else $error("request dropped without ack");
    a_oe_suspend: assert property (irq_oe == !ctl_ff[1])
        else $error("pin enable wrong");
    a_ctrl_read: assert property (s_read(CTRL_OFS)
        |=> rdata == {1'b0, $past(ctl_ff), 5'h00})
        else $error("control readback wrong");
    a_mask_read: assert property (s_read(MASK0_OFS) |=> rdata == $past(m0_ff))
        else $error("mask readback wrong");
    a_unmapped_zero: assert property (rd && (addr < CTRL_OFS || addr > MASK2_OFS)
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind e1_framer_interrupt_masking irq_mask_props i_props (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .frame_sync_loss(frame_sync_loss),
    .frame_slip(frame_slip), .irq_n(irq_n), .irq_oe(irq_oe));

// *** tb/tb_top.sv ***
// self-checking bench for the interrupt masking block
`timescale 1ns/1ps
module tb_top
    import irq_mask_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [23:0] src = 24'h000000;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] got;
    logic wr;
    logic rd;
    logic irq_n;
    logic irq_oe;
    logic ack = 1'b0;
    int mismatches = 0;
    int total_checks = 0;
    localparam logic [7:0] VEC [24] = '{8'h04, 8'h10, 8'h20, 8'h40, 8'h40, 8'h40, 8'h40, 8'h80,
        8'h01, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20,
        8'h10, 8'h40, 8'h10, 8'h04, 8'h10, 8'h08, 8'h10, 8'h10};
    initial
    begin
        forever #5 clk = ~clk;
    end
    host_bus i_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    // short alarm timer counts keep the run brief
    e1_framer_interrupt_masking #(.LONG_CYCLES(20), .WIN_CYCLES(100)) i_dut (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .frame_sync_loss(src[7]), .remote_alarm(src[6]), .all_ones_alarm(src[5]),
        .ch16_all_ones_alarm(src[4]), .signal_loss(src[3]), .align_word_error(src[2]),
        .line_violation_wrap(src[1]), .frame_slip(src[0]), .far_end_crc_error(src[15]),
        .local_crc_error(src[14]), .double_align_error(src[13]), .line_violation(src[12]),
        .alarm_crc_level(src[11]), .tester_bit_error(src[9]), .signalling_change(src[8]),
        .far_end_count_ovf(src[23]), .crc_count_ovf(src[22]), .crc_align_status(src[21]),
        .align_count_ovf(src[20]), .jitter_fifo_margin(src[19]), .tester_count_ovf(src[18]),
        .aux_pattern_status(src[17]), .multiframe_count_ovf(src[16]), .irq_n(irq_n),
        .irq_oe(irq_oe));
    task automatic check8(input logic [7:0] act, input logic [7:0] exp);
        total_checks++;
        if (act !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, act, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        i_host.read_reg(a, got);
        check8(got, e);
    endtask
    task automatic ack_irq;
        ack = ~ack;
        i_host.write_reg(CTRL_OFS, ack ? 8'h20 : 8'h00);
    endtask
    task automatic set_masks(input logic [7:0] m0, input logic [7:0] m1, input logic [7:0] m2);
        i_host.write_reg(MASK0_OFS, m0);
        i_host.write_reg(MASK1_OFS, m1);
        i_host.write_reg(MASK2_OFS, m2);
    endtask
    task automatic pulse(input int k, input int len);
        src[k] <= 1'b1;
        repeat (len) @(posedge clk);
        src[k] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (50000) @(posedge clk);
        mismatches++;
        $display("unexpected at %0t: run hung", $time);
        summarize();
    end
    initial
    begin
        int k;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check8({7'h00, irq_n}, 8'h01);
        rd_chk(MASK0_OFS, 8'h00);
        rd_chk(MASK1_OFS, 8'h00);
        rd_chk(MASK2_OFS, 8'h00);
        rd_chk(VECTOR_OFS, 8'h00);
        rd_chk(5'h05, 8'h00);
        // each source alone enabled, then all masked; index 10 is the window timer
        for (int i = 0; i < 24; i++)
        begin
            k = (i == 10) ? 11 : i;
            set_masks(i < 8 ? ~(8'h01 << i) : 8'hff, (i > 7 && i < 16) ? 8'h01 << (i - 8) : 8'h00,
                i > 15 ? 8'h01 << (i - 16) : 8'h00);
            pulse(k, (k == 11) ? 25 : 1);
            rd_chk(VECTOR_OFS, VEC[i]);
            check8({7'h00, irq_n}, 8'h00);
            ack_irq();
            rd_chk(VECTOR_OFS, 8'h00);
            check8({7'h00, irq_n}, 8'h01);
            set_masks(8'hff, 8'h00, 8'h00);
            pulse(k, (k == 11) ? 25 : 1);
            rd_chk(VECTOR_OFS, 8'h00);
        end
        set_masks(8'hff, 8'h08, 8'h00);
        rd_chk(MASK1_OFS, 8'h08);
        pulse(11, 20);
        rd_chk(VECTOR_OFS, 8'h00);
        set_masks(8'hff, 8'h04, 8'h00);
        pulse(11, 120);
        rd_chk(VECTOR_OFS, 8'h00);
        set_masks(8'h00, 8'h00, 8'h00);
        // a level still high in the acknowledge cycle sets the vector again
        src[7] <= 1'b1;
        ack_irq();
        rd_chk(VECTOR_OFS, 8'h80);
        src[7] <= 1'b0;
        ack_irq();
        rd_chk(VECTOR_OFS, 8'h00);
        pulse(0, 1);
        i_host.write_reg(CTRL_OFS, ack ? 8'h60 : 8'h40);
        check8({7'h00, irq_oe}, 8'h00);
        rd_chk(CTRL_OFS, ack ? 8'h60 : 8'h40);
        rd_chk(VECTOR_OFS, 8'h04);
        check8({7'h00, irq_n}, 8'h00);
        ack = ~ack;
        i_host.write_reg(CTRL_OFS, ack ? 8'h60 : 8'h40);
        rd_chk(VECTOR_OFS, 8'h00);
        pulse(7, 1);
        rd_chk(VECTOR_OFS, 8'h00);
        i_host.write_reg(CTRL_OFS, ack ? 8'h20 : 8'h00);
        check8({7'h00, irq_oe}, 8'h01);
        check8({7'h00, irq_n}, 8'h01);
        summarize();
    end
endmodule
